// ==== core/picture_line_formatter.sv ====
// Picture adjust, line type formatter and reset control of the decoder
//
// Behaviour
// RL1: Luma is contrast/68 times centred luma plus brightness
// RL2: Chroma is saturation/64 times centred chroma plus 128
// RL3: Every adjusted output clipped to 1..254
// RL4: Contrast, brightness, saturation reset to 44h, 80h, 40h
// RL5: Raw composite has own gain and offset
// RL6: Pseudo sync detection readable at status byte
// RL7: Missing clock resets; outputs disabled during reset
// RL8: Reset indicator low 128 cycles after reset
// RL9: Controller may reset by pulsing chip enable low
// RL10: After enable, only clocks return; other outputs wait for the output enable bit
// RL11: Raw and VBI tags decoded from line type
// RL12: Entries 2 to 23 each select one line
// RL13: Entry 24 covers the rest of field
// RL14: Upper nibble odd field, lower nibble even field
// RL15: Vertical and field offsets shift entry mapping
// RL16: Software sets offsets 03h/0 or 06h/1
// RL17: Types 6 and 15 component, others raw
// RL18: Eleven-bit horizontal pixel offset held, split
// RL19: Selectable reference timing to both ports
// RL20: Comb and chroma delay off on raw lines
// RL21: Unsigned samples, truncation toward zero, per sample
`timescale 1ns/1ps
module picture_line_formatter
    import line_formatter_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Pins
    input  wire logic        chip_enable_in,
    input  wire logic        clock_missing_in,
    output logic             reset_indicator_n_out,
    output logic             clocks_oe_out,
    output logic             others_oe_out,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [7:0]       reg_rdata_out,
    // Line position and sync status
    input  wire logic [9:0]  line_in,
    input  wire logic        field_even_in,
    input  wire logic        pseudo_sync_in,
    // Reference timing sources
    input  wire timing_t     dec_timing_in,
    input  wire timing_t     alt_timing_in,
    output logic             realtime_control_out,
    output timing_t          expansion_timing_out,
    // Sample stream in
    input  wire logic        sample_valid_in,
    input  wire sample_in_t  sample_in,
    output logic             sample_ready_out,
    // Tagged sample stream out
    output logic             tagged_valid_out,
    output sample_out_t      tagged_out,
    input  wire logic        tagged_ready_in,
    // Filter control
    output logic             comb_bypass_out,
    output logic             chroma_delay_off_out
);
    localparam int HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);

    logic             ce_meta_reg;
    logic             ce_sync_reg;
    logic             miss_meta_reg;
    logic             miss_sync_reg;
    logic             int_rst;
    logic [HOLD_W-1:0] hold_cnt_reg;

    logic [7:0]  contrast_gain_reg;
    logic [7:0]  brightness_level_reg;
    logic [7:0]  saturation_gain_reg;
    logic [7:0]  raw_sample_gain_reg;
    logic [7:0]  raw_sample_offset_reg;
    logic [7:0]  out_ctrl_reg;
    logic [8:0]  vert_line_offset_reg;
    logic        field_offset_bit_reg;
    logic [10:0] horiz_pixel_offset_reg;
    logic [7:0]  line_type_entry_reg [ENTRY_COUNT];
    logic        copy_protect_flag_reg;

    logic [9:0]  entry_idx;
    logic [7:0]  entry_byte;
    logic [3:0]  line_type;
    logic        component_line;
    logic        vbi_type_flag;
    sample_out_t adj_sample;
    logic        entry_wr;
    logic [7:0]  entry_off;

    // Centre, scale with truncation toward zero, add, then clip
    function automatic logic [7:0] adjust(input logic [7:0] s,
                                          input logic [7:0] g,
                                          input int         div,
                                          input logic [7:0] add);
        logic signed [18:0] ctr;
        logic signed [18:0] prod;
        logic signed [18:0] sum;
        ctr  = $signed({11'h000, s}) - $signed({11'h000, MID_LEVEL});
        prod = ctr * $signed({11'h000, g});
        sum  = prod / $signed(19'(div)) + $signed({11'h000, add});
        // RL3: clip to legal range
        if (sum < $signed({11'h000, CLIP_MIN})) begin
            adjust = CLIP_MIN;
        end else if (sum > $signed({11'h000, CLIP_MAX})) begin
            adjust = CLIP_MAX;
        end else begin
            adjust = sum[7:0];
        end
    endfunction

    // Pins cross from outside through two flops
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ce_meta_reg   <= 1'b0;
            ce_sync_reg   <= 1'b0;
            miss_meta_reg <= 1'b0;
            miss_sync_reg <= 1'b0;
        end else begin
            ce_meta_reg   <= chip_enable_in;
            ce_sync_reg   <= ce_meta_reg;
            miss_meta_reg <= clock_missing_in;
            miss_sync_reg <= miss_meta_reg;
        end
    end

    // RL7: missing clock resets
    // RL9: low chip enable resets
    assign int_rst = rst_in || !ce_sync_reg || miss_sync_reg;

    // RL8: indicator held after reset
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            hold_cnt_reg          <= '0;
            reset_indicator_n_out <= 1'b0;
        end else begin
            if (hold_cnt_reg != HOLD_W'(RESET_HOLD_CYCLES)) begin
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
            reset_indicator_n_out <=
                hold_cnt_reg == HOLD_W'(RESET_HOLD_CYCLES);
        end
    end

    // RL10: clocks return, others wait
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            clocks_oe_out <= 1'b0;
            others_oe_out <= 1'b0;
        end else begin
            clocks_oe_out <= 1'b1;
            others_oe_out <= out_ctrl_reg[OUT_EN_BIT];
        end
    end

    assign entry_off = reg_addr_in - ADDR_ENTRY_LO;
    assign entry_wr  = reg_wr_in && reg_addr_in >= ADDR_ENTRY_LO
                       && reg_addr_in <= ADDR_ENTRY_HI;

    // RL4: nominal defaults
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            contrast_gain_reg     <= CONTRAST_RST;
            brightness_level_reg  <= BRIGHT_RST;
            saturation_gain_reg   <= SATURATION_RST;
            raw_sample_gain_reg   <= RAW_GAIN_RST;
            raw_sample_offset_reg <= RAW_OFS_RST;
            out_ctrl_reg          <= OUT_CTRL_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_CONTRAST:   contrast_gain_reg     <= reg_wdata_in;
                ADDR_BRIGHT:     brightness_level_reg  <= reg_wdata_in;
                ADDR_SATURATION: saturation_gain_reg   <= reg_wdata_in;
                ADDR_RAW_GAIN:   raw_sample_gain_reg   <= reg_wdata_in;
                ADDR_RAW_OFS:    raw_sample_offset_reg <= reg_wdata_in;
                ADDR_OUT_CTRL:   out_ctrl_reg          <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // RL15: offsets at 5ah/5bh
    // RL18: pixel offset split over 59h/5bh
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            vert_line_offset_reg   <= VERT_LINE_OFFSET_RST;
            field_offset_bit_reg   <= 1'b0;
            horiz_pixel_offset_reg <= HORIZ_PIXEL_OFFSET_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_HORIZ_PIXEL_OFFSET_LO: horiz_pixel_offset_reg[7:0] <= reg_wdata_in;
                ADDR_VERT_LINE_OFFSET_LO: vert_line_offset_reg[7:0]   <= reg_wdata_in;
                ADDR_OFF_HI: begin
                    field_offset_bit_reg     <= reg_wdata_in[FIELD_OFFSET_BIT_BIT];
                    vert_line_offset_reg[8]  <= reg_wdata_in[VOFF8_BIT];
                    horiz_pixel_offset_reg[10:8] <=
                        reg_wdata_in[HORIZ_PIXEL_OFFSET_HI_MSB:0];
                end
                default: ;
            endcase
        end
    end

    // RL12: one entry per line 2..23
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            for (int i = 0; i < ENTRY_COUNT; i++) begin
                line_type_entry_reg[i] <= ENTRY_RST;
            end
        end else if (entry_wr) begin
            line_type_entry_reg[entry_off[4:0]] <= reg_wdata_in;
        end
    end

    // RL6: pseudo sync flag follows the detector
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            copy_protect_flag_reg <= 1'b0;
        end else begin
            copy_protect_flag_reg <= pseudo_sync_in;
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= '0;
            case (reg_addr_in)
                ADDR_STATUS:
                    reg_rdata_out[COPY_FLAG_BIT] <= copy_protect_flag_reg;
                ADDR_CONTRAST:   reg_rdata_out <= contrast_gain_reg;
                ADDR_BRIGHT:     reg_rdata_out <= brightness_level_reg;
                ADDR_SATURATION: reg_rdata_out <= saturation_gain_reg;
                ADDR_RAW_GAIN:   reg_rdata_out <= raw_sample_gain_reg;
                ADDR_RAW_OFS:    reg_rdata_out <= raw_sample_offset_reg;
                ADDR_OUT_CTRL:   reg_rdata_out <= out_ctrl_reg;
                ADDR_HORIZ_PIXEL_OFFSET_LO:
                    reg_rdata_out <= horiz_pixel_offset_reg[7:0];
                ADDR_VERT_LINE_OFFSET_LO:
                    reg_rdata_out <= vert_line_offset_reg[7:0];
                ADDR_OFF_HI: begin
                    reg_rdata_out[FIELD_OFFSET_BIT_BIT]  <= field_offset_bit_reg;
                    reg_rdata_out[VOFF8_BIT] <= vert_line_offset_reg[8];
                    reg_rdata_out[HORIZ_PIXEL_OFFSET_HI_MSB:0] <=
                        horiz_pixel_offset_reg[10:8];
                end
                default: begin
                    if (entry_off < 8'(ENTRY_COUNT)) begin
                        reg_rdata_out <= line_type_entry_reg[entry_off[4:0]];
                    end
                end
            endcase
        end
    end

    // RL15: line shifted by vertical and field offsets
    assign entry_idx = line_in - {1'b0, vert_line_offset_reg}
                       - {9'h000, field_even_in && field_offset_bit_reg};

    // RL13: lines outside 2..23 take entry 24
    always_comb begin
        if (entry_idx >= 10'(FIRST_ENTRY) && entry_idx <= 10'(LAST_SEL)) begin
            entry_byte = line_type_entry_reg[5'(entry_idx
                                              - 10'(FIRST_ENTRY))];
        end else begin
            entry_byte = line_type_entry_reg[ENTRY_COUNT - 1];
        end
    end

    // RL14: nibble chosen by field
    assign line_type = field_even_in ? entry_byte[3:0] : entry_byte[7:4];

    // RL17: types 6 and 15 are component
    assign component_line = line_type == TYPE_VBI_COMP
                            || line_type == TYPE_ACT_COMP;
    // RL11: tags decoded from line type
    assign vbi_type_flag  = line_type != TYPE_ACT_COMP;

    // RL21: one sample per clock, toward-zero truncation
    always_comb begin
        adj_sample.raw_line = !component_line;
        adj_sample.vbi_line = vbi_type_flag;
        if (component_line) begin
            // RL1: contrast and brightness
            adj_sample.luma = adjust(sample_in.luma, contrast_gain_reg,
                                     CONTRAST_DIV, brightness_level_reg);
            // RL2: saturation around mid level
            adj_sample.chroma = adjust(sample_in.chroma,
                                       saturation_gain_reg, SAT_DIV,
                                       MID_LEVEL);
        end else begin
            // RL5: raw gain and offset
            adj_sample.luma = adjust(sample_in.luma, raw_sample_gain_reg,
                                     RAW_DIV, raw_sample_offset_reg);
            adj_sample.chroma = MID_LEVEL;
        end
    end

    // Buffer absorbs a receiver stall without losing a sample
    sample_skid_fifo #(
        .WIDTH ($bits(sample_out_t)),
        .DEPTH (BUF_DEPTH)
    ) u_sample_skid_fifo (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (int_rst),
        .wr_valid_in  (sample_valid_in),
        .wr_data_in   (adj_sample),
        .wr_ready_out (sample_ready_out),
        .rd_valid_out (tagged_valid_out),
        .rd_data_out  (tagged_out),
        .rd_ready_in  (tagged_ready_in)
    );

    // RL20: filters off on raw or VBI lines
    // RL19: reference timing per port
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            comb_bypass_out      <= 1'b0;
            chroma_delay_off_out <= 1'b0;
            realtime_control_out <= 1'b0;
            expansion_timing_out <= '0;
        end else begin
            comb_bypass_out      <= vbi_type_flag;
            chroma_delay_off_out <= vbi_type_flag;
            realtime_control_out <= out_ctrl_reg[RT_SEL_BIT] ?
                                    alt_timing_in.hs : dec_timing_in.hs;
            expansion_timing_out <= out_ctrl_reg[XP_SEL_BIT] ?
                                    alt_timing_in : dec_timing_in;
        end
    end

    // Helper: cycles since internal reset release
    logic [HOLD_W:0] rel_cnt_reg;
    always_ff @(posedge ref_clk_in) begin
        if (int_rst) begin
            rel_cnt_reg <= '0;
        end else if (!rel_cnt_reg[HOLD_W]) begin
            rel_cnt_reg <= rel_cnt_reg + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_indicator_hold: assert property ( // RL8
        $rose(reset_indicator_n_out) |->
            rel_cnt_reg == (HOLD_W + 1)'(RESET_HOLD_CYCLES + 1))
        else $error("reset indicator released at wrong time");

    chk_reset_tristate: assert property ( // RL7
        int_rst |=> !clocks_oe_out && !others_oe_out
                    && !reset_indicator_n_out)
        else $error("outputs enabled during reset");

    chk_enable_order: assert property ( // RL10
        $rose(clocks_oe_out) |-> !others_oe_out)
        else $error("other outputs enabled before programming");

    chk_defaults_load: assert property ( // RL4
        $fell(int_rst) |-> contrast_gain_reg == CONTRAST_RST
            && brightness_level_reg == BRIGHT_RST
            && saturation_gain_reg == SATURATION_RST)
        else $error("picture adjust defaults wrong");

    chk_clip_range: assert property ( // RL3
        tagged_valid_out |-> tagged_out.luma >= CLIP_MIN
            && tagged_out.luma <= CLIP_MAX
            && tagged_out.chroma >= CLIP_MIN
            && tagged_out.chroma <= CLIP_MAX)
        else $error("sample outside legal range");

    chk_copy_flag: assert property ( // RL6
        !int_rst ##1 !int_rst && reg_rd_in
            && reg_addr_in == ADDR_STATUS |=>
            reg_rdata_out[COPY_FLAG_BIT] == $past(pseudo_sync_in, 2))
        else $error("copy protect flag not reported");

    chk_line_type_tag: assert property ( // RL17
        !int_rst && sample_valid_in && sample_ready_out ##1 !int_rst
            && $past(line_type) == TYPE_ACT_COMP |->
            !$past(adj_sample.raw_line) && !comb_bypass_out)
        else $error("active component line tagged raw");

    chk_stall_holds: assert property ( // skid buffer holds stalled sample
        tagged_valid_out && !tagged_ready_in && !int_rst ##1 !int_rst
            |-> tagged_valid_out && $stable(tagged_out))
        else $error("stalled sample lost or changed");

    chk_neutral_luma: assert property ( // RL1
        component_line && contrast_gain_reg == CONTRAST_RST
            && brightness_level_reg == MID_LEVEL
            && sample_in.luma >= CLIP_MIN && sample_in.luma <= CLIP_MAX
            |-> adj_sample.luma == sample_in.luma)
        else $error("nominal contrast changed luma");

    cov_raw_line:    cover property (tagged_valid_out && tagged_out.raw_line);
    cov_comp_line:   cover property (tagged_valid_out && !tagged_out.raw_line);
    cov_stall_full:  cover property (!sample_ready_out && !tagged_ready_in);
    cov_ce_reset:    cover property ($rose(reset_indicator_n_out));

endmodule

// ==== core/sample_skid_fifo.sv ====
// Small shift-register FIFO whose head is always a flip-flop
`timescale 1ns/1ps
module sample_skid_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    // Filling side
    input  wire logic             wr_valid_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  wr_ready_out,
    // Draining side
    output logic                  rd_valid_out,
    output logic [WIDTH-1:0]      rd_data_out,
    input  wire logic             rd_ready_in
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic [CW-1:0]    wr_pos;
    logic             push;
    logic             pop;

    assign push = wr_valid_in && wr_ready_out;
    assign pop  = rd_valid_out && rd_ready_in;
    assign wr_pos = count_reg - CW'(pop);
    assign count_next = count_reg + CW'(push) - CW'(pop);
    assign rd_data_out = slot_reg[0];

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_reg    <= '0;
            rd_valid_out <= 1'b0;
            wr_ready_out <= 1'b1;
        end else begin
            count_reg    <= count_next;
            rd_valid_out <= count_next != '0;
            wr_ready_out <= count_next != CW'(DEPTH);
        end
    end

    // Entries shift toward the head on every pop
    always_ff @(posedge ref_clk_in) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && wr_pos == CW'(i)) begin
                slot_reg[i] <= wr_data_in;
            end else if (pop && i < DEPTH - 1) begin
                slot_reg[i] <= slot_reg[(i + 1) % DEPTH];
            end
        end
    end

endmodule

// ==== pkg/line_formatter_pkg.sv ====
// Constants, register map and carrier types of the picture formatter
package line_formatter_pkg;

    // Register subaddresses
    localparam logic [7:0] ADDR_STATUS     = 8'h1f;
    localparam logic [7:0] ADDR_HORIZ_PIXEL_OFFSET_LO    = 8'h59;
    localparam logic [7:0] ADDR_VERT_LINE_OFFSET_LO    = 8'h5a;
    localparam logic [7:0] ADDR_OFF_HI     = 8'h5b;
    localparam logic [7:0] ADDR_ENTRY_LO   = 8'h41;
    localparam logic [7:0] ADDR_ENTRY_HI   = 8'h57;
    localparam logic [7:0] ADDR_BRIGHT     = 8'h0a;
    localparam logic [7:0] ADDR_CONTRAST   = 8'h0b;
    localparam logic [7:0] ADDR_SATURATION = 8'h0c;
    localparam logic [7:0] ADDR_RAW_GAIN   = 8'h0d;
    localparam logic [7:0] ADDR_RAW_OFS    = 8'h0e;
    localparam logic [7:0] ADDR_OUT_CTRL   = 8'h0f;

    // Field positions
    localparam int FIELD_OFFSET_BIT_BIT      = 7;
    localparam int VOFF8_BIT     = 4;
    localparam int HORIZ_PIXEL_OFFSET_HI_MSB   = 2;
    localparam int COPY_FLAG_BIT = 6;
    localparam int OUT_EN_BIT    = 0;
    localparam int RT_SEL_BIT    = 1;
    localparam int XP_SEL_BIT    = 2;

    // Reset values
    localparam logic [7:0]  CONTRAST_RST   = 8'h44;
    localparam logic [7:0]  BRIGHT_RST     = 8'h80;
    localparam logic [7:0]  SATURATION_RST = 8'h40;
    localparam logic [7:0]  RAW_GAIN_RST   = 8'h40;
    localparam logic [7:0]  RAW_OFS_RST    = 8'h80;
    localparam logic [8:0]  VERT_LINE_OFFSET_RST       = 9'h003;
    localparam logic [10:0] HORIZ_PIXEL_OFFSET_RST       = 11'h347;
    localparam logic [7:0]  ENTRY_RST      = 8'hff;
    localparam logic [7:0]  OUT_CTRL_RST   = 8'h00;

    // Arithmetic
    localparam int          CONTRAST_DIV = 68;
    localparam int          SAT_DIV      = 64;
    localparam int          RAW_DIV      = 64;
    localparam logic [7:0]  MID_LEVEL    = 8'h80;
    localparam logic [7:0]  CLIP_MIN     = 8'h01;
    localparam logic [7:0]  CLIP_MAX     = 8'hfe;

    // Line table
    localparam int         FIRST_ENTRY = 2;
    localparam int         LAST_SEL    = 23;
    localparam int         REST_ENTRY  = 24;
    localparam int         ENTRY_COUNT = REST_ENTRY - FIRST_ENTRY + 1;
    localparam logic [3:0] TYPE_VBI_COMP = 4'h6;
    localparam logic [3:0] TYPE_ACT_COMP = 4'hf;

    // Reset indicator hold, in line-locked clock cycles
    localparam int RESET_HOLD_CYCLES = 128;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } sample_in_t;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
        logic       raw_line;
        logic       vbi_line;
    } sample_out_t;

    typedef struct packed {
        logic hs;
        logic vs;
        logic dq;
    } timing_t;

endpackage

// ==== tb/tag_sink.sv ====
// Consumer model of the tagged sample stream
`timescale 1ns/1ps
module tag_sink
    import line_formatter_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Stream
    input  wire logic        tagged_valid_in,
    input  wire sample_out_t tagged_in,
    output logic             tagged_ready_out,
    // Bench side
    input  wire logic        stall_in,
    output sample_out_t      last_out,
    output logic [7:0]       count_out
);
    // Stall holds words in the formatter
    assign tagged_ready_out = !stall_in;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_out <= 8'h00;
        end else if (tagged_valid_in && tagged_ready_out) begin
            last_out  <= tagged_in;
            count_out <= count_out + 8'h01;
        end
    end
endmodule

// ==== tb/tb_picture_line_formatter.sv ====
// Self-checking bench of the picture line formatter
`timescale 1ns/1ps
module tb_picture_line_formatter;
    import line_formatter_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        chip_enable_in = 1'b1;
    logic        clock_missing_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [9:0]  line_in = 10'h064;
    logic        field_even_in = 1'b0;
    logic        pseudo_sync_in = 1'b0;
    logic        sample_valid_in = 1'b0;
    sample_in_t  sample_in = '{8'h90, 8'h80};
    logic        stall = 1'b0;
    logic        reset_indicator_n_out, clocks_oe_out, others_oe_out;
    logic        sample_ready_out, tagged_valid_out, tagged_ready_in;
    logic        realtime_control_out, comb_bypass_out, chroma_delay_off_out;
    logic [7:0]  reg_rdata_out, cnt;
    timing_t     expansion_timing_out;
    sample_out_t tagged_out, last;
    int          fails = 0;
    int          comparisons = 0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    picture_line_formatter u_picture_line_formatter (
        .ref_clk_in, .rst_in, .chip_enable_in, .clock_missing_in,
        .reset_indicator_n_out, .clocks_oe_out, .others_oe_out,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .line_in, .field_even_in, .pseudo_sync_in,
        .dec_timing_in(3'h5), .alt_timing_in(3'h2), .realtime_control_out,
        .expansion_timing_out, .sample_valid_in, .sample_in,
        .sample_ready_out, .tagged_valid_out, .tagged_out, .tagged_ready_in,
        .comb_bypass_out, .chroma_delay_off_out);
    tag_sink u_tag_sink (.ref_clk_in, .rst_in,
        .tagged_valid_in(tagged_valid_out),
        .tagged_in(tagged_out), .tagged_ready_out(tagged_ready_in),
        .stall_in(stall), .last_out(last), .count_out(cnt));
    task automatic chk(input string nm, input logic [17:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic to_fail();
        fails++;
        end_sim();
    endtask
    task automatic wr_reg(input logic [7:0] a, v);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk("reg", reg_rdata_out, exp);
    endtask
    task automatic send(input logic [7:0] y, c);
        int n;
        @(posedge ref_clk_in);
        sample_in <= '{y, c};
        sample_valid_in <= 1'b1;
        @(negedge ref_clk_in);
        for (n = 0; n < 50 && sample_ready_out !== 1'b1; n++)
            @(negedge ref_clk_in);
        if (n == 50) to_fail();
        @(posedge ref_clk_in);
        sample_valid_in <= 1'b0;
    endtask
    task automatic take(input logic [7:0] c, input logic [17:0] exp);
        int n;
        for (n = 0; n < 50 && cnt !== c; n++) @(negedge ref_clk_in);
        if (n == 50) to_fail();
        chk("sample", last, exp);
    endtask
    task automatic hold_chk();
        int n;
        for (n = 0; n < 200 && reset_indicator_n_out !== 1'b1; n++)
            @(negedge ref_clk_in);
        if (n == 200) to_fail();
        chk("hold", n >= 125 && n <= 135, 1'b1);
        #1 chk("clk_oe", clocks_oe_out, 1'b1);
        chk("oth_oe", others_oe_out, 1'b0);
    endtask
    task automatic t_regs();
        rd_chk(ADDR_CONTRAST, 8'h44);
        rd_chk(ADDR_BRIGHT, 8'h80);
        rd_chk(ADDR_SATURATION, 8'h40);
        rd_chk(8'h30, 8'h00);
        // Offsets as for 60 Hz sources
        wr_reg(ADDR_VERT_LINE_OFFSET_LO, 8'h06);
        wr_reg(ADDR_OFF_HI, 8'h83);
        wr_reg(ADDR_HORIZ_PIXEL_OFFSET_LO, 8'h48);
        rd_chk(ADDR_OFF_HI, 8'h83);
        rd_chk(ADDR_HORIZ_PIXEL_OFFSET_LO, 8'h48);
        pseudo_sync_in <= 1'b1;
        rd_chk(ADDR_STATUS, 8'h40);
    endtask
    task automatic t_stream();
        wr_reg(ADDR_CONTRAST, 8'h88);
        wr_reg(ADDR_SATURATION, 8'h20);
        stall <= 1'b1;
        send(8'hf0, 8'h01);
        send(8'h10, 8'hff);
        #1 chk("full", {sample_ready_out, tagged_valid_out}, 2'b01);
        chk("comb_act", {comb_bypass_out, chroma_delay_off_out}, 2'b00);
        chk("head", tagged_out, {8'hfe, 8'h41, 2'b00});
        stall <= 1'b0;
        take(8'h02, {8'h01, 8'hbf, 2'b00});
    endtask
    task automatic t_lines();
        wr_reg(ADDR_ENTRY_LO, 8'h67);
        wr_reg(ADDR_RAW_GAIN, 8'h20);
        line_in <= 10'h008;
        send(8'h90, 8'h80);
        take(8'h03, {8'ha0, 8'h80, 2'b01});
        field_even_in <= 1'b1;
        line_in <= 10'h009;
        send(8'h00, 8'h80);
        take(8'h04, {8'h40, 8'h80, 2'b11});
        chk("comb", {comb_bypass_out, chroma_delay_off_out}, 2'b11);
        wr_reg(ADDR_ENTRY_HI, 8'h3f);
        line_in <= 10'h064;
        field_even_in <= 1'b0;
        send(8'h30, 8'h20);
        take(8'h05, {8'h58, 8'h80, 2'b11});
    endtask
    task automatic t_timing();
        chk("xp", {realtime_control_out, expansion_timing_out}, 4'hd);
        wr_reg(ADDR_OUT_CTRL, 8'h07);
        repeat (2) @(posedge ref_clk_in);
        #1 chk("xp_alt", expansion_timing_out, 3'h2);
        chk("rt", realtime_control_out, 1'b0);
        chk("oth_on", others_oe_out, 1'b1);
    endtask
    task automatic t_ce();
        // Controller pulls enable low then releases it
        chip_enable_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #1 chk("ce_rst", reset_indicator_n_out, 1'b0);
        chk("ce_oe", {clocks_oe_out, others_oe_out}, 2'b00);
        chip_enable_in <= 1'b1;
        hold_chk();
        // Clock monitor reports a lost clock
        clock_missing_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        #1 chk("miss_rst", reset_indicator_n_out, 1'b0);
        chk("miss_oe", {clocks_oe_out, others_oe_out}, 2'b00);
        clock_missing_in <= 1'b0;
        hold_chk();
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        hold_chk();
        t_regs();
        t_stream();
        t_lines();
        t_timing();
        t_ce();
        end_sim();
    end
endmodule
